/* File: lcse_pkg.sv */
/*
  Shared types and constants of the ladder coil scan engine: program word
  layout, coil and contact codes, operating modes and timing counts.
  Assumes a 50 MHz scan clock.
*/
package lcse_pkg;

  localparam int          CLK_HZ       = 50_000_000;
  localparam int          RUNGS        = 256;
  localparam int          CONTACTS     = 4;
  localparam int          RELAYS       = 128;
  localparam int          INPUTS       = 16;
  localparam int          OUTPUTS      = 16;
  localparam int          SYNC_W       = INPUTS + 2;
  localparam logic [4:0]  STATION_MAX  = 5'h1F;
  localparam int          ACK_WAIT_US  = 10;
  localparam int          ACK_WAIT_CYC = (ACK_WAIT_US * CLK_HZ) / 1_000_000;
  localparam logic [7:0]  LAST_RUNG    = 8'hFF;
  localparam logic [7:0]  OPERAND_RELAY_BIT = 8'h80;

  // empty field passes power straight on; open field blocks it
  typedef enum logic [1:0] {
    LCSE_C_WIRE,
    LCSE_C_NO,
    LCSE_C_NC,
    LCSE_C_OPEN
  } lcse_contact_kind_t;

  typedef enum logic [3:0] {
    LCSE_F_NONE,
    LCSE_F_CONTACTOR,
    LCSE_F_INVERSE,
    LCSE_F_IMPULSE,
    LCSE_F_SET,
    LCSE_F_RESET,
    LCSE_F_RISE,
    LCSE_F_FALL,
    LCSE_F_BLOCK
  } lcse_coil_func_t;

  typedef enum logic [1:0] {
    LCSE_M_STOP,
    LCSE_M_SETUP,
    LCSE_M_RUN
  } lcse_mode_t;

  // operand bit 7 set: relay 0..127, clear: input 0..15
  typedef struct packed {
    lcse_contact_kind_t kind;
    logic [7:0]         operand;
  } lcse_contact_t;

  typedef struct packed {
    lcse_coil_func_t func;
    logic [6:0]      target;
  } lcse_coil_t;

  typedef struct packed {
    lcse_contact_t [CONTACTS-1:0] contact;
    lcse_coil_t                   coil;
  } lcse_rung_t;

  typedef struct packed {
    logic       valid;
    logic [6:0] block;
    logic       value;
  } lcse_block_io_t;

  typedef struct packed {
    logic       valid;
    logic [7:0] rung;
    logic [3:0] contacts;
    logic       power;
  } lcse_flow_t;

endpackage

/* File: lcse_scan_engine.sv */
/*
  Ladder coil scan engine: rung program store, cyclic evaluator with
  relay image, station bus setup and target comparison, mode control.
  Assumes program writes come from a loader on the same clock; the pins
  in_pins, power_fail and station_ack arrive asynchronously.
*/
`timescale 1ns/1ps
`default_nettype none

// Behaviour
// - scan the whole program repeatedly, only while running
// - program store holds 256 rungs
// - each rung: four series contacts then one coil
// - first contact is fed with logic 1
// - make contact passes its operand
// - break contact passes the inverted operand
// - coils are written only while running
// - contactor coil takes the rung result every scan
// - impulse coil toggles on each rising rung result
// - non-retentive relays cleared on stop or power failure
// - retentive relays keep their state over stop and power failure
// - set coil latches 1 until a reset coil clears it
// - set and reset together: higher rung wins
// - inverse coil outputs the complement of the rung result
// - several non-retentive coils: last evaluated one wins
// - set, reset, impulse coils may repeat for one relay
// - function block coils evaluated in program order each scan
// - stations addressed one after another in ascending order
// - discovered station count stored as nonvolatile target
// - line lamp steady when discovered set equals target
// - run starts only if project station list matches target
// - editing only in stop; power flow shown while running
// - rising pulse coil high for one scan after 0 to 1
// - falling pulse coil high for one scan after 1 to 0
module lcse_scan_engine (
  input  wire logic                          clk,
  input  wire logic                          nrst,
  input  wire logic [lcse_pkg::INPUTS-1:0]   in_pins,
  input  wire logic                          power_fail,
  input  wire logic                          run_req,
  input  wire logic                          stop_req,
  input  wire logic                          setup_req,
  input  wire logic                          prog_we,
  input  wire logic [7:0]                    prog_addr,
  input  wire lcse_pkg::lcse_rung_t          prog_data,
  input  wire logic [lcse_pkg::RELAYS-1:0]   retain_mask,
  input  wire logic [4:0]                    project_stations,
  input  wire logic [4:0]                    nv_target,
  input  wire logic                          station_ack,
  input  wire logic                          block_result,
  output logic [lcse_pkg::OUTPUTS-1:0]       q_out,
  output logic                               running,
  output logic                               scan_done,
  output logic                               prog_rejected,
  output lcse_pkg::lcse_block_io_t           block_out,
  output lcse_pkg::lcse_flow_t               flow_out,
  output logic [4:0]                         station_addr,
  output logic                               addr_strobe,
  output logic                               nv_store,
  output logic [4:0]                         nv_store_data,
  output logic                               line_status_lamp,
  output logic                               setup_lamp,
  output logic                               run_refused
);

  // program memory, written only in stop
  lcse_pkg::lcse_rung_t prog_mem [lcse_pkg::RUNGS];

  // pin synchroniser: three stages, value taken when stages two and three agree
  logic [lcse_pkg::SYNC_W-1:0] s1_q, s2_q, s3_q, filt_q, filt_d;
  logic [lcse_pkg::INPUTS-1:0] in_f;
  logic                        pfail_f, ack_f;

  lcse_pkg::lcse_mode_t mode_q, mode_d;
  logic [7:0]                  rung_q, rung_d;
  logic [lcse_pkg::RELAYS-1:0] relay_q, relay_d;
  logic [lcse_pkg::RUNGS-1:0]  prev_q, prev_d;
  logic [4:0]                  target_q, target_d;
  logic [4:0]                  found_q, found_d;
  logic [4:0]                  addr_q, addr_d;
  logic [15:0]                 wait_q, wait_d;
  logic                        loaded_q, loaded_d;
  logic                        strobe_q, strobe_d;
  logic                        nvs_q, nvs_d;
  logic                        done_q, done_d;
  logic                        rej_q, rej_d;
  logic                        refused_q, refused_d;
  logic                        run_q, run_d;
  logic                        ack_p_q, ack_p_d;
  logic                        lamp_q, lamp_d;
  logic                        setup_lamp_q, setup_lamp_d;
  lcse_pkg::lcse_block_io_t    blk_q, blk_d;
  lcse_pkg::lcse_flow_t        flow_q, flow_d;

  function automatic logic contact_pass(
    input lcse_pkg::lcse_contact_t c,
    input logic                    v
  );
    unique case (c.kind)
      lcse_pkg::LCSE_C_WIRE: contact_pass = 1'b1;
      lcse_pkg::LCSE_C_NO:   contact_pass = v;
      lcse_pkg::LCSE_C_NC:   contact_pass = ~v;
      lcse_pkg::LCSE_C_OPEN: contact_pass = 1'b0;
    endcase
  endfunction

  // retentive relays survive, the rest drop to 0
  function automatic logic [lcse_pkg::RELAYS-1:0] drop_relays(
    input logic [lcse_pkg::RELAYS-1:0] r,
    input logic [lcse_pkg::RELAYS-1:0] keep
  );
    drop_relays = r & keep;
  endfunction

  assign in_f    = filt_q[lcse_pkg::INPUTS-1:0];
  assign pfail_f = filt_q[lcse_pkg::INPUTS];
  assign ack_f   = filt_q[lcse_pkg::INPUTS+1];

  always_comb begin
    filt_d = filt_q;
    for (int i = 0; i < lcse_pkg::SYNC_W; i++) begin
      if (s2_q[i] == s3_q[i]) begin
        filt_d[i] = s3_q[i];
      end
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      s1_q   <= '0;
      s2_q   <= '0;
      s3_q   <= '0;
      filt_q <= '0;
    end else begin
      s1_q   <= {station_ack, power_fail, in_pins};
      s2_q   <= s1_q;
      s3_q   <= s2_q;
      filt_q <= filt_d;
    end
  end

  // edits refused outside stop, so a running scan never sees a torn rung
  always_ff @(posedge clk) begin
    if (prog_we && mode_q == lcse_pkg::LCSE_M_STOP) begin
      prog_mem[prog_addr] <= prog_data;
    end
  end

  // rung evaluation, one rung per clock
  lcse_pkg::lcse_rung_t cur;
  logic [3:0]           pass;
  logic                 power;
  logic                 opv;
  logic                 prev;

  always_comb begin
    cur   = prog_mem[rung_q];
    power = 1'b1;
    pass  = '0;
    opv   = 1'b0;
    for (int i = 0; i < lcse_pkg::CONTACTS; i++) begin
      if (cur.contact[i].operand[7]) begin
        opv = relay_q[cur.contact[i].operand[6:0]];
      end else begin
        opv = in_f[cur.contact[i].operand[3:0]];
      end
      power   = power & contact_pass(cur.contact[i], opv);
      pass[i] = power;
    end
    prev = prev_q[rung_q];
  end

  always_comb begin
    mode_d       = mode_q;
    rung_d       = rung_q;
    relay_d      = relay_q;
    prev_d       = prev_q;
    target_d     = target_q;
    found_d      = found_q;
    addr_d       = addr_q;
    wait_d       = wait_q;
    loaded_d     = 1'b1;
    strobe_d     = 1'b0;
    nvs_d        = 1'b0;
    done_d       = 1'b0;
    rej_d        = prog_we && mode_q != lcse_pkg::LCSE_M_STOP;
    refused_d    = 1'b0;
    ack_p_d      = ack_f;
    lamp_d       = lamp_q;
    setup_lamp_d = setup_lamp_q;
    blk_d        = '0;
    flow_d       = '0;
    if (!loaded_q) begin
      target_d = nv_target;
    end
    unique case (mode_q)
      lcse_pkg::LCSE_M_STOP: begin
        rung_d = '0;
        if (setup_req) begin
          mode_d       = lcse_pkg::LCSE_M_SETUP;
          addr_d       = 5'h01;
          found_d      = '0;
          wait_d       = '0;
          strobe_d     = 1'b1;
          setup_lamp_d = 1'b1;
          lamp_d       = 1'b0;
        end else if (run_req && !pfail_f) begin
          if (project_stations == target_q) begin
            mode_d = lcse_pkg::LCSE_M_RUN;
          end else begin
            refused_d = 1'b1;
          end
        end
      end
      lcse_pkg::LCSE_M_SETUP: begin
        // one address step per acknowledge, however long it stands
        if (ack_f && !ack_p_q) begin
          found_d = addr_q;
          wait_d  = '0;
          if (addr_q == lcse_pkg::STATION_MAX) begin
            wait_d = 16'(lcse_pkg::ACK_WAIT_CYC);
          end else begin
            addr_d   = addr_q + 5'h01;
            strobe_d = 1'b1;
          end
        end else begin
          wait_d = wait_q + 16'h0001;
        end
        if (wait_q >= 16'(lcse_pkg::ACK_WAIT_CYC)) begin
          mode_d       = lcse_pkg::LCSE_M_STOP;
          target_d     = found_q;
          nvs_d        = 1'b1;
          setup_lamp_d = 1'b0;
        end
      end
      lcse_pkg::LCSE_M_RUN: begin
        flow_d.valid    = 1'b1;
        flow_d.rung     = rung_q;
        flow_d.contacts = pass;
        flow_d.power    = power;
        prev_d[rung_q]  = power;
        // writes land in the relay image at once for later rungs
        unique case (cur.coil.func)
          lcse_pkg::LCSE_F_NONE: begin
          end
          lcse_pkg::LCSE_F_CONTACTOR:
            relay_d[cur.coil.target] = power;
          lcse_pkg::LCSE_F_INVERSE:
            relay_d[cur.coil.target] = ~power;
          lcse_pkg::LCSE_F_IMPULSE:
            if (power && !prev) begin
              relay_d[cur.coil.target] = ~relay_q[cur.coil.target];
            end
          lcse_pkg::LCSE_F_SET:
            if (power) begin
              relay_d[cur.coil.target] = 1'b1;
            end
          lcse_pkg::LCSE_F_RESET:
            if (power) begin
              relay_d[cur.coil.target] = 1'b0;
            end
          lcse_pkg::LCSE_F_RISE:
            relay_d[cur.coil.target] = power & ~prev;
          lcse_pkg::LCSE_F_FALL:
            relay_d[cur.coil.target] = ~power & prev;
          lcse_pkg::LCSE_F_BLOCK: begin
            blk_d.valid = 1'b1;
            blk_d.block = cur.coil.target;
            blk_d.value = power;
            // block answer lands in the matching relay bit
            relay_d[cur.coil.target] = block_result;
          end
          default: begin
          end
        endcase
        rung_d = rung_q + 8'h01;
        if (rung_q == lcse_pkg::LAST_RUNG) begin
          done_d = 1'b1;
        end
        if (stop_req || pfail_f) begin
          mode_d  = lcse_pkg::LCSE_M_STOP;
          relay_d = drop_relays(relay_q, retain_mask);
          prev_d  = '0;
          rung_d  = '0;
        end
      end
      default: mode_d = lcse_pkg::LCSE_M_STOP;
    endcase
    // power loss outside run still drops the volatile relays
    if (pfail_f && mode_q != lcse_pkg::LCSE_M_RUN) begin
      relay_d = drop_relays(relay_q, retain_mask);
    end
    if (mode_q != lcse_pkg::LCSE_M_SETUP) begin
      lamp_d = (found_q == target_d) && loaded_q;
    end
    run_d = (mode_d == lcse_pkg::LCSE_M_RUN);
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      mode_q       <= lcse_pkg::LCSE_M_STOP;
      rung_q       <= '0;
      relay_q      <= '0;
      prev_q       <= '0;
      target_q     <= '0;
      found_q      <= '0;
      addr_q       <= '0;
      wait_q       <= '0;
      loaded_q     <= 1'b0;
      strobe_q     <= 1'b0;
      nvs_q        <= 1'b0;
      done_q       <= 1'b0;
      rej_q        <= 1'b0;
      refused_q    <= 1'b0;
      run_q        <= 1'b0;
      ack_p_q      <= 1'b0;
      lamp_q       <= 1'b0;
      setup_lamp_q <= 1'b0;
      blk_q        <= '0;
      flow_q       <= '0;
    end else begin
      mode_q       <= mode_d;
      rung_q       <= rung_d;
      relay_q      <= relay_d;
      prev_q       <= prev_d;
      target_q     <= target_d;
      found_q      <= found_d;
      addr_q       <= addr_d;
      wait_q       <= wait_d;
      loaded_q     <= loaded_d;
      strobe_q     <= strobe_d;
      nvs_q        <= nvs_d;
      done_q       <= done_d;
      rej_q        <= rej_d;
      refused_q    <= refused_d;
      run_q        <= run_d;
      ack_p_q      <= ack_p_d;
      lamp_q       <= lamp_d;
      setup_lamp_q <= setup_lamp_d;
      blk_q        <= blk_d;
      flow_q       <= flow_d;
    end
  end

  assign q_out            = relay_q[lcse_pkg::OUTPUTS-1:0];
  assign running          = run_q;
  assign scan_done        = done_q;
  assign prog_rejected    = rej_q;
  assign block_out        = blk_q;
  assign flow_out         = flow_q;
  assign station_addr     = addr_q;
  assign addr_strobe      = strobe_q;
  assign nv_store         = nvs_q;
  assign nv_store_data    = target_q;
  assign line_status_lamp = lamp_q;
  assign setup_lamp       = setup_lamp_q;
  assign run_refused      = refused_q;

endmodule

`default_nettype wire

/* File: lcse_chk.sv */
/*
  Checker of the scan engine: mode, scan length, program write refusal,
  station setup order. Sees only top ports; bound after the module.
*/
`timescale 1ns/1ps
`default_nettype none
module lcse_chk (
  input wire logic                         clk,
  input wire logic                         nrst,
  input wire logic                         run_req,
  input wire logic                         stop_req,
  input wire logic                         prog_we,
  input wire logic [lcse_pkg::RELAYS-1:0]  retain_mask,
  input wire logic [lcse_pkg::OUTPUTS-1:0] q_out,
  input wire logic                         running,
  input wire logic                         scan_done,
  input wire logic                         prog_rejected,
  input wire lcse_pkg::lcse_flow_t         flow_out,
  input wire logic [4:0]                   station_addr,
  input wire logic                         addr_strobe,
  input wire logic                         nv_store,
  input wire logic                         setup_lamp,
  input wire logic                         run_refused
);
  logic       run_p_q;
  logic [8:0] gap_q;
  logic [8:0] gap_d;

  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);

  // cycles since last scan end; restarts on entry to run
  always_comb begin
    gap_d = (gap_q == 9'h1FF) ? gap_q : gap_q + 9'h001;
    if (scan_done || (running && !run_p_q)) begin
      gap_d = 9'h001;
    end
  end
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      run_p_q <= 1'b0;
      gap_q   <= 9'h000;
    end else begin
      run_p_q <= running;
      gap_q   <= gap_d;
    end
  end

  sequence s_one(x);
    x ##1 !x;
  endsequence

  stay_stop_a: assert property (!running && !run_req |=> !running)
    else $error("left stop without run request");
  scan_len_a: assert property (running && run_p_q |->
    scan_done == (gap_q == 9'h100)) else $error("scan not 256 cycles");
  flow_first_a: assert property ($rose(running) |=>
    flow_out.valid && flow_out.rung == 8'h00) else $error("scan start");
  flow_order_a: assert property (
    flow_out.valid && $past(flow_out.valid) |->
    flow_out.rung == $past(flow_out.rung) + 8'h01)
    else $error("rung order");
  stop_mode_a: assert property (running && stop_req |=> !running)
    else $error("stop not taken");
  stop_clear_a: assert property ($fell(running) |-> ##1
    (q_out & ~retain_mask[15:0]) == 16'h0000) else $error("not cleared");
  coil_hold_a: assert property (!running && !$past(running) &&
    !$past(running, 2) |-> $stable(q_out)) else $error("coil moved");
  run_refuse_a: assert property (run_refused |-> !running &&
    $past(run_req)) else $error("bad refusal");
  edit_reject_a: assert property (prog_we && running |=> prog_rejected)
    else $error("write in run not flagged");
  edit_accept_a: assert property (prog_we && !running && !setup_lamp
    |=> !prog_rejected) else $error("write in stop flagged");
  addr_first_a: assert property ($rose(setup_lamp) |-> addr_strobe &&
    station_addr == 5'h01) else $error("first address");
  addr_next_a: assert property (addr_strobe && $past(setup_lamp) |->
    station_addr == $past(station_addr) + 5'h01)
    else $error("address not ascending");
  store_once_a: assert property ($fell(setup_lamp) |-> s_one(nv_store))
    else $error("target not stored");
endmodule

bind lcse_scan_engine lcse_chk i_chk (.clk(clk), .nrst(nrst),
  .run_req(run_req), .stop_req(stop_req), .prog_we(prog_we),
  .retain_mask(retain_mask), .q_out(q_out), .running(running),
  .scan_done(scan_done), .prog_rejected(prog_rejected),
  .flow_out(flow_out), .station_addr(station_addr),
  .addr_strobe(addr_strobe), .nv_store(nv_store),
  .setup_lamp(setup_lamp), .run_refused(run_refused));
`default_nettype wire

/* File: lcse_station_model.sv */
/*
  Model of the stations on the wiring bus: each present station answers
  its address with a two-cycle acknowledge, promptly or slowly.
*/
`timescale 1ns/1ps
`default_nettype none
module lcse_station_model #(
  parameter int STATIONS = 3
) (
  input  wire logic       clk,
  input  wire logic       nrst,
  input  wire logic [4:0] station_addr,
  input  wire logic       addr_strobe,
  input  wire logic       slow,
  output var  logic       station_ack
);
  logic [5:0] wait_q;

  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      wait_q      <= 6'h00;
      station_ack <= 1'b0;
    end else begin
      // missing stations stay silent so setup ends by timeout
      if (addr_strobe && station_addr != 5'h00 &&
          station_addr <= 5'(STATIONS)) begin
        wait_q <= slow ? 6'h1E : 6'h03;
      end else if (wait_q != 6'h00) begin
        wait_q <= wait_q - 6'h01;
      end
      station_ack <= (wait_q == 6'h02) || (wait_q == 6'h01);
    end
  end
endmodule
`default_nettype wire

/* File: test_ladder_coil_scan_engine.sv */
/*
  Bench of the scan engine: load, refusal, setup, coil functions, stop.
  Assumes the checker binds itself and three stations on the bus.
*/
`timescale 1ns/1ps
`default_nettype none
module test_ladder_coil_scan_engine;
  logic        clk, nrst, run_req, stop_req, setup_req, prog_we, slow;
  logic        station_ack, addr_strobe, running, prog_rejected, nv_store;
  logic        line_status_lamp, setup_lamp, run_refused, power_fail;
  logic [15:0] in_pins, q_out;
  logic [7:0]  prog_addr;
  logic [4:0]  project_stations, nv_target, station_addr, nv_store_data;
  logic [4:0]  addrs[$];
  int          fails, num_checks, rf_n, rj_n, p5, p6;
  logic [127:0]         retain_mask;
  lcse_pkg::lcse_rung_t prog_data;
  lcse_pkg::lcse_block_io_t blk;

  lcse_scan_engine i_dut (.clk(clk), .nrst(nrst), .in_pins(in_pins),
    .power_fail(power_fail), .run_req(run_req), .stop_req(stop_req),
    .setup_req(setup_req), .prog_we(prog_we), .prog_addr(prog_addr),
    .prog_data(prog_data), .retain_mask(retain_mask),
    .project_stations(project_stations), .nv_target(nv_target),
    .station_ack(station_ack), .block_result(1'b0), .q_out(q_out),
    .running(running), .scan_done(), .prog_rejected(prog_rejected),
    .block_out(blk), .flow_out(), .station_addr(station_addr),
    .addr_strobe(addr_strobe), .nv_store(nv_store),
    .nv_store_data(nv_store_data), .line_status_lamp(line_status_lamp),
    .setup_lamp(setup_lamp), .run_refused(run_refused));
  lcse_station_model #(.STATIONS(3)) i_sta (.clk(clk), .nrst(nrst),
    .station_addr(station_addr), .addr_strobe(addr_strobe), .slow(slow),
    .station_ack(station_ack));

  initial clk = 1'b0;
  always #10 clk = ~clk;

  // one-cycle outputs are caught at every falling edge
  always @(negedge clk) begin
    if (run_refused === 1'b1) rf_n++;
    if (prog_rejected === 1'b1) rj_n++;
    if (addr_strobe === 1'b1) addrs.push_back(station_addr);
  end

  task automatic tick(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    num_checks++;
    if (g !== e) begin
      fails++;
      $display("wrong value t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic req(ref logic s);
    s = 1'b1;
    tick(1);
    s = 1'b0;
  endtask
  task automatic wr(input int a, input lcse_pkg::lcse_contact_kind_t k,
                    input logic [7:0] op, input lcse_pkg::lcse_coil_func_t f,
                    input logic [6:0] t);
    prog_addr = 8'(a);
    prog_data = '0;
    prog_data.contact[0].kind = k;
    prog_data.contact[0].operand = op;
    prog_data.coil.func = f;
    prog_data.coil.target = t;
    prog_we = 1'b1;
    tick(1);
  endtask
  task automatic pulses(input logic [15:0] pins);
    in_pins = pins;
    p5 = 0;
    p6 = 0;
    repeat (1024) begin
      tick(1);
      p5 += (q_out[5] === 1'b1);
      p6 += (q_out[6] === 1'b1);
    end
  endtask

  task automatic t_load;
    // each plain coil fed from a single rung only
    for (int i = 0; i < 256; i++) wr(i, lcse_pkg::LCSE_C_WIRE, 8'h00,
      lcse_pkg::LCSE_F_NONE, 7'h00);
    wr(0, lcse_pkg::LCSE_C_NO, 8'h00, lcse_pkg::LCSE_F_CONTACTOR, 7'h00);
    wr(1, lcse_pkg::LCSE_C_NC, 8'h01, lcse_pkg::LCSE_F_CONTACTOR, 7'h01);
    wr(2, lcse_pkg::LCSE_C_NO, 8'h00, lcse_pkg::LCSE_F_INVERSE, 7'h02);
    wr(3, lcse_pkg::LCSE_C_NO, 8'h00, lcse_pkg::LCSE_F_IMPULSE, 7'h03);
    wr(4, lcse_pkg::LCSE_C_NO, 8'h02, lcse_pkg::LCSE_F_SET, 7'h04);
    wr(5, lcse_pkg::LCSE_C_NO, 8'h03, lcse_pkg::LCSE_F_RESET, 7'h04);
    wr(6, lcse_pkg::LCSE_C_NO, 8'h00, lcse_pkg::LCSE_F_RISE, 7'h05);
    wr(7, lcse_pkg::LCSE_C_NO, 8'h00, lcse_pkg::LCSE_F_FALL, 7'h06);
    wr(8, lcse_pkg::LCSE_C_NO, 8'h80, lcse_pkg::LCSE_F_CONTACTOR, 7'h07);
    wr(9, lcse_pkg::LCSE_C_WIRE, 8'h00, lcse_pkg::LCSE_F_CONTACTOR, 7'h09);
    wr(11, lcse_pkg::LCSE_C_WIRE, 8'h00, lcse_pkg::LCSE_F_BLOCK, 7'h20);
    wr(255, lcse_pkg::LCSE_C_NO, 8'h00, lcse_pkg::LCSE_F_CONTACTOR, 7'h08);
    prog_we = 1'b0;
    tick(2);
    req(run_req);
    tick(4);
    chk(16'(rf_n), 16'h0001);
    chk(running, 1'b0);
    $display("load and refusal done");
  endtask
  task automatic t_setup(input logic s);
    int n;
    slow = s;
    addrs.delete();
    req(setup_req);
    for (n = 0; n < 3000 && nv_store !== 1'b1; n++) tick(1);
    chk(nv_store, 1'b1);
    chk(nv_store_data, 5'h03);
    chk(16'(addrs.size()), 16'h0004);
    foreach (addrs[i]) chk(addrs[i], 16'(i + 1));
    tick(2);
    chk(line_status_lamp, 1'b1);
    $display("setup done");
  endtask
  task automatic t_run;
    int n;
    project_stations = 5'h03;
    req(run_req);
    for (n = 0; n < 8 && running !== 1'b1; n++) tick(1);
    chk(running, 1'b1);
    wr(10, lcse_pkg::LCSE_C_WIRE, 8'h00, lcse_pkg::LCSE_F_NONE, 7'h00);
    prog_we = 1'b0;
    tick(3);
    chk(16'(rj_n), 16'h0001);
    tick(600);
    chk(q_out, 16'h0206);
    for (n = 0; n < 300 && blk.valid !== 1'b1; n++) tick(1);
    chk(16'(blk), 16'h0141);
    pulses(16'h0003);
    chk(q_out, 16'h0389);
    chk(16'(p5), 16'h0100);
    chk(16'(p6), 16'h0000);
    pulses(16'h0002);
    chk(q_out, 16'h020C);
    chk(16'(p6), 16'h0100);
    in_pins = 16'h0003;
    tick(600);
    chk(q_out, 16'h0381);
    $display("coil test done");
  endtask
  task automatic t_latch;
    logic [15:0] pins [4] = '{16'h0004, 16'h0000, 16'h000C, 16'h0004};
    logic [15:0] want [4] = '{16'h0216, 16'h0216, 16'h0206, 16'h0216};
    for (int i = 0; i < 4; i++) begin
      in_pins = pins[i];
      tick(600);
      chk(q_out, want[i]);
    end
    req(stop_req);
    tick(3);
    chk(running, 1'b0);
    chk(q_out, 16'h0010);
    in_pins = 16'h0003;
    tick(600);
    chk(q_out, 16'h0010);
    // edge memory was cleared on stop, so the impulse coil toggles again
    req(run_req);
    tick(600);
    chk(q_out, 16'h0399);
    power_fail = 1'b1;
    tick(8);
    chk(running, 1'b0);
    chk(q_out, 16'h0010);
    power_fail = 1'b0;
    $display("latch and stop done");
  endtask

  task automatic finish_test;
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  initial begin
    repeat (30000) @(posedge clk);
    fails++;
    finish_test();
  end

  initial begin
    {nrst, run_req, stop_req, setup_req, prog_we, slow, power_fail} = 7'h00;
    in_pins = 16'h0000;
    prog_addr = 8'h00;
    prog_data = '0;
    retain_mask = 128'h10;
    project_stations = 5'h02;
    nv_target = 5'h03;
    tick(5);
    nrst = 1'b1;
    tick(2);
    chk(q_out, 16'h0000);
    chk(running, 1'b0);
    t_load();
    t_setup(1'b0);
    t_setup(1'b1);
    t_run();
    t_latch();
    finish_test();
  end
endmodule
`default_nettype wire
